// ===== core/nvm_ctrl.sv
`timescale 1ns/1ps
module nvm_ctrl (
	input wire logic clock,
	input wire logic rst,
	input wire logic cmd_valid,
	input wire logic [7:0] cmd_code,
	input wire logic [nvm_pkg::ADDR_W-1:0] cmd_addr,
	input wire logic [63:0] cmd_data,
	input wire logic [2:0] cmd_words,
	input wire logic done_irq_en,
	input wire logic ecc_irq_en,
	input wire logic rd_en,
	input wire logic [nvm_pkg::ADDR_W-1:0] rd_addr,
	input wire logic rd_word,
	output logic command_complete_flag,
	output logic cmd_error,
	output logic verify_fail,
	output logic rd_valid,
	output logic [15:0] rd_data,
	output logic ecc_single,
	output logic ecc_double,
	output logic done_irq,
	output logic ecc_irq
);
	import nvm_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// arrays and ecc

	logic [P_HW+P_DW:0] pmem [P_ENTRIES];
	logic [D_HW+D_DW:0] dmem [D_ENTRIES];

	state_t state_q, state_d;
	logic [TMR_W-1:0] tmr_q, tmr_d;
	logic [7:0] idx_q, idx_d;
	logic [7:0] cnt_q, cnt_d;
	logic to_p_q, to_p_d, erase_q, erase_d;
	logic [P_IDX_W-1:0] pbase_q, pbase_d;
	logic [D_IDX_W-1:0] dbase_q, dbase_d;
	logic [63:0] data_q, data_d;
	logic flag_q, flag_d, err_q, err_d, fail_q, fail_d;

	logic [P_IDX_W-1:0] p_widx;
	logic [D_IDX_W-1:0] d_widx;
	logic [P_DW-1:0] p_wdata;
	logic [D_DW-1:0] d_wdata;
	logic [P_HW:0] p_wchk;
	logic [D_HW:0] d_wchk;
	logic [P_HW+P_DW:0] p_expect;
	logic [D_HW+D_DW:0] d_expect;
	logic p_we, d_we;
	logic [23:0] p_roff, d_roff;
	logic [P_HW+P_DW:0] p_rword;
	logic [D_HW+D_DW:0] d_rword;
	logic [P_DW-1:0] p_cor;
	logic [D_DW-1:0] d_cor;
	logic p_sgl, p_dbl, d_sgl, d_dbl;
	assign p_widx = pbase_q + {7'h00, idx_q};
	assign d_widx = dbase_q + idx_q;
	assign p_wdata = idx_q[0] ? data_q[63:32] : data_q[31:0];
	assign d_wdata = data_q[{idx_q[1:0], 4'h0} +: 16];

	// parity is generated here, the host never supplies check bits
	secded #(.DW(P_DW), .HW(P_HW)) u_pecc (
		.enc_data(p_wdata),
		.enc_check(p_wchk),
		.dec_data(p_rword[P_DW-1:0]),
		.dec_check(p_rword[P_HW+P_DW:P_DW]),
		.cor_data(p_cor),
		.single_err(p_sgl),
		.double_err(p_dbl)
	);

	secded #(.DW(D_DW), .HW(D_HW)) u_decc (
		.enc_data(d_wdata),
		.enc_check(d_wchk),
		.dec_data(d_rword[D_DW-1:0]),
		.dec_check(d_rword[D_HW+D_DW:D_DW]),
		.cor_data(d_cor),
		.single_err(d_sgl),
		.double_err(d_dbl)
	);

	// erase drives every cell, check bits included, back to ones
	assign p_expect = erase_q ? '1 : {p_wchk, p_wdata};
	assign d_expect = erase_q ? '1 : {d_wchk, d_wdata};

	////////////////////////////////////////////////////////////////////////////
	// command sequencer

	logic [23:0] c_poff, c_doff;
	logic c_in_p, c_in_d;
	logic [8:0] c_dend;

	assign c_poff = cmd_addr - PFL_BASE;
	assign c_doff = cmd_addr - DFL_BASE;
	assign c_in_p = cmd_addr >= PFL_BASE;
	assign c_in_d = (cmd_addr >= DFL_BASE) && (cmd_addr < DFL_BASE + DFL_BYTES);
	assign c_dend = {1'b0, c_doff[8:1]} + {6'h00, cmd_words};

	always_comb begin
		state_d = state_q;
		tmr_d = tmr_q;
		idx_d = idx_q;
		cnt_d = cnt_q;
		to_p_d = to_p_q;
		erase_d = erase_q;
		pbase_d = pbase_q;
		dbase_d = dbase_q;
		data_d = data_q;
		flag_d = flag_q;
		err_d = err_q;
		fail_d = fail_q;
		p_we = 1'b0;
		d_we = 1'b0;
		unique case (state_q)
			ST_IDLE: begin
				if (cmd_valid) begin
					err_d = 1'b1;
					fail_d = 1'b0;
					pbase_d = c_poff[P_IDX_W+1:2];
					dbase_d = c_doff[D_IDX_W:1];
					data_d = cmd_data;
					idx_d = 8'h00;
					if (cmd_code == CMD_PGM_PHRASE && c_in_p && c_poff[2:0] == 3'h0) begin
						err_d = 1'b0;
						to_p_d = 1'b1;
						erase_d = 1'b0;
						cnt_d = 8'(PHRASE_DWORDS);
						tmr_d = TMR_W'(PGM_CYC);
					end else if (cmd_code == CMD_ERS_PSECTOR && c_in_p && c_poff[8:0] == 9'h000) begin
						err_d = 1'b0;
						to_p_d = 1'b1;
						erase_d = 1'b1;
						cnt_d = 8'(P_SECTOR_DWORDS);
						tmr_d = TMR_W'(ERS_CYC);
					end else if (cmd_code == CMD_PGM_DWORDS && c_in_d && c_doff[0] == 1'b0 && cmd_words != 3'h0
							&& cmd_words <= 3'(D_BURST_MAX) && c_dend <= 9'(D_ENTRIES)) begin
						err_d = 1'b0;
						to_p_d = 1'b0;
						erase_d = 1'b0;
						cnt_d = {5'h00, cmd_words};
						tmr_d = TMR_W'(PGM_CYC);
					end else if (cmd_code == CMD_ERS_DSECTOR && c_in_d && c_doff[1:0] == 2'h0) begin
						err_d = 1'b0;
						to_p_d = 1'b0;
						erase_d = 1'b1;
						cnt_d = 8'(D_SECTOR_WORDS);
						tmr_d = TMR_W'(ERS_CYC);
					end
					if (!err_d) begin
						flag_d = 1'b0;
						state_d = ST_WAIT;
					end
				end
			end
			ST_WAIT: begin
				tmr_d = tmr_q - 1'b1;
				if (tmr_q == TMR_W'(1)) begin
					state_d = ST_WRITE;
				end
			end
			ST_WRITE: begin
				p_we = to_p_q;
				d_we = !to_p_q;
				idx_d = idx_q + 1'b1;
				if (idx_q == cnt_q - 1'b1) begin
					idx_d = 8'h00;
					state_d = ST_VERIFY;
				end
			end
			ST_VERIFY: begin
				if (to_p_q ? (pmem[p_widx] != p_expect) : (dmem[d_widx] != d_expect)) begin
					fail_d = 1'b1;
				end
				idx_d = idx_q + 1'b1;
				if (idx_q == cnt_q - 1'b1) begin
					idx_d = 8'h00;
					flag_d = 1'b1;
					state_d = ST_IDLE;
				end
			end
		endcase
		// a load attempt while busy is refused and only reported
		if (cmd_valid && state_q != ST_IDLE) begin
			err_d = 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			state_q <= ST_IDLE;
			tmr_q <= '0;
			idx_q <= 8'h00;
			cnt_q <= 8'h00;
			to_p_q <= 1'b0;
			erase_q <= 1'b0;
			pbase_q <= '0;
			dbase_q <= '0;
			data_q <= 64'h0000000000000000;
			flag_q <= 1'b1;
			err_q <= 1'b0;
			fail_q <= 1'b0;
		end else begin
			state_q <= state_d;
			tmr_q <= tmr_d;
			idx_q <= idx_d;
			cnt_q <= cnt_d;
			to_p_q <= to_p_d;
			erase_q <= erase_d;
			pbase_q <= pbase_d;
			dbase_q <= dbase_d;
			data_q <= data_d;
			flag_q <= flag_d;
			err_q <= err_d;
			fail_q <= fail_d;
		end
	end

	// programming can only clear cells, so a repeated program never sets a bit back
	always_ff @(posedge clock) begin
		if (p_we) begin
			pmem[p_widx] <= erase_q ? '1 : (pmem[p_widx] & p_expect);
		end
		if (d_we) begin
			dmem[d_widx] <= erase_q ? '1 : (dmem[d_widx] & d_expect);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// read port; the two arrays have separate read paths

	logic rd_valid_q, rd_valid_d;
	logic [15:0] rd_data_q, rd_data_d;
	logic sgl_q, sgl_d, dbl_q, dbl_d;
	logic done_irq_q, done_irq_d, ecc_irq_q, ecc_irq_d;
	logic [15:0] p_half;

	assign p_roff = rd_addr - PFL_BASE;
	assign d_roff = rd_addr - DFL_BASE;
	assign p_rword = pmem[p_roff[P_IDX_W+1:2]];
	assign d_rword = dmem[d_roff[D_IDX_W:1]];
	// big-endian lanes; a misaligned word address is served as the aligned word below it
	assign p_half = p_roff[1] ? p_cor[15:0] : p_cor[31:16];

	always_comb begin
		rd_valid_d = rd_en;
		rd_data_d = 16'h0000;
		sgl_d = 1'b0;
		dbl_d = 1'b0;
		if (rd_en) begin
			if (rd_addr >= PFL_BASE) begin
				rd_data_d = rd_word ? p_half : {8'h00, (rd_addr[0] ? p_half[7:0] : p_half[15:8])};
				sgl_d = p_sgl;
				dbl_d = p_dbl;
			end else if (rd_addr >= DFL_BASE && rd_addr < DFL_BASE + DFL_BYTES) begin
				rd_data_d = rd_word ? d_cor : {8'h00, (rd_addr[0] ? d_cor[7:0] : d_cor[15:8])};
				sgl_d = d_sgl;
				dbl_d = d_dbl;
			end else if (rd_addr >= RES_BASE && rd_addr <= RES_LAST) begin
				rd_data_d = rd_word ? 16'hFFFF : 16'h00FF;
			end else if (rd_addr <= REG_LAST_USED) begin // control locations read as zero here
				rd_data_d = 16'h0000;
			end
		end
		done_irq_d = done_irq_en && flag_q;
		ecc_irq_d = ecc_irq_en && (sgl_d || dbl_d);
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			rd_valid_q <= 1'b0;
			rd_data_q <= 16'h0000;
			sgl_q <= 1'b0;
			dbl_q <= 1'b0;
			done_irq_q <= 1'b0;
			ecc_irq_q <= 1'b0;
		end else begin
			rd_valid_q <= rd_valid_d;
			rd_data_q <= rd_data_d;
			sgl_q <= sgl_d;
			dbl_q <= dbl_d;
			done_irq_q <= done_irq_d;
			ecc_irq_q <= ecc_irq_d;
		end
	end

	assign command_complete_flag = flag_q;
	assign cmd_error = err_q;
	assign verify_fail = fail_q;
	assign rd_valid = rd_valid_q;
	assign rd_data = rd_data_q;
	assign ecc_single = sgl_q;
	assign ecc_double = dbl_q;
	assign done_irq = done_irq_q;
	assign ecc_irq = ecc_irq_q;

endmodule : nvm_ctrl

// ===== core/nvm_pkg.sv
// Operation
// - no new command until current finishes
// - byte and aligned word reads, one cycle
// - erased bits read one, programmed read zero
// - program array readable during data commands
// - both arrays correct single, detect double faults
// - program reads per half-phrase, one correction
// - data array erases four-byte sectors
// - phrase is two double words, seven checks
// - program array erases 512-byte sectors
// - data array holds 128 four-byte sectors
// - one to four data words per burst
// - internal program, erase, verify, parity generation
// - requests on completion and memory error
// - unmapped reads undefined, writes ignored
// - registers, data, resource, program address map
// - control registers span offsets 0x00 to 0x17
package nvm_pkg;

	localparam int CLK_NS = 5;
	localparam int PGM_TIME_NS = 10000;
	localparam int ERS_TIME_NS = 20000;
	localparam int PGM_CYC = (PGM_TIME_NS + CLK_NS - 1) / CLK_NS;
	localparam int ERS_CYC = (ERS_TIME_NS + CLK_NS - 1) / CLK_NS;
	localparam int TMR_W = 12;

	localparam int ADDR_W = 24;
	localparam logic [23:0] REG_BASE = 24'h000000;
	localparam logic [23:0] REG_SPAN = 24'h001000;
	localparam logic [23:0] REG_LAST_USED = 24'h000017;
	localparam logic [23:0] DFL_BASE = 24'h100000;
	localparam logic [23:0] DFL_BYTES = 24'h000200;
	localparam logic [23:0] RES_BASE = 24'h1F4000;
	localparam logic [23:0] RES_LAST = 24'h1FFFFF;
	localparam logic [23:0] PFL_BASE = 24'hFE0000;

	// program array: 32-bit double words, 6 hamming + 1 overall check bits
	localparam int P_DW = 32;
	localparam int P_HW = 6;
	localparam int P_ENTRIES = 32768;
	localparam int P_IDX_W = 15;
	localparam int PHRASE_DWORDS = 2;
	localparam int P_SECTOR_BYTES = 512;
	localparam int P_SECTORS = 256;
	localparam int P_SECTOR_DWORDS = P_SECTOR_BYTES / 4;
	// data array: 16-bit words, 5 hamming + 1 overall check bits
	localparam int D_DW = 16;
	localparam int D_HW = 5;
	localparam int D_ENTRIES = 256;
	localparam int D_IDX_W = 8;
	localparam int D_SECTOR_BYTES = 4;
	localparam int D_SECTORS = 128;
	localparam int D_SECTOR_WORDS = D_SECTOR_BYTES / 2;
	localparam int D_BURST_MAX = 4;

	localparam logic [7:0] CMD_PGM_PHRASE = 8'h06;
	localparam logic [7:0] CMD_ERS_PSECTOR = 8'h0A;
	localparam logic [7:0] CMD_PGM_DWORDS = 8'h11;
	localparam logic [7:0] CMD_ERS_DSECTOR = 8'h12;

	typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_WRITE, ST_VERIFY} state_t;

endpackage : nvm_pkg

// ===== core/secded.sv
`timescale 1ns/1ps
// hamming code with overall parity; an all-ones word is the erased state and decodes clean
module secded #(
	parameter int DW = 32,
	parameter int HW = 6
) (
	input wire logic [DW-1:0] enc_data,
	output logic [HW:0] enc_check,
	input wire logic [DW-1:0] dec_data,
	input wire logic [HW:0] dec_check,
	output logic [DW-1:0] cor_data,
	output logic single_err,
	output logic double_err
);

	function automatic int pos_of(input int j);
		int p;
		int n;
		p = 0;
		n = 0;
		for (int q = 3; q < 128; q++) begin
			if ((q & (q - 1)) != 0) begin
				if (n == j && p == 0) begin
					p = q;
				end
				n++;
			end
		end
		return p;
	endfunction : pos_of

	logic [HW-1:0] syn;
	logic erased;
	logic overall;

	for (genvar gi = 0; gi < HW; gi++) begin : g_chk
		logic [DW-1:0] sel;
		for (genvar gj = 0; gj < DW; gj++) begin : g_sel
			localparam int P = pos_of(gj);
			assign sel[gj] = P[gi];
		end
		assign enc_check[gi] = ^(enc_data & sel);
		assign syn[gi] = dec_check[gi] ^ (^(dec_data & sel));
	end

	assign enc_check[HW] = (^enc_data) ^ (^enc_check[HW-1:0]);
	assign erased = &{dec_data, dec_check};
	assign overall = ^{dec_data, dec_check};
	assign single_err = !erased && overall;
	assign double_err = !erased && !overall && (syn != '0);

	for (genvar gj = 0; gj < DW; gj++) begin : g_cor
		localparam int P = pos_of(gj);
		assign cor_data[gj] = dec_data[gj] ^ (single_err && (syn == P[HW-1:0]));
	end

endmodule : secded

// ===== test/cpu_host.sv
`timescale 1ns/1ps
module cpu_host (
	input wire logic clock,
	output logic cmd_valid,
	output logic [7:0] cmd_code,
	output logic [nvm_pkg::ADDR_W-1:0] cmd_addr,
	output logic [63:0] cmd_data,
	output logic [2:0] cmd_words,
	output logic rd_en,
	output logic [nvm_pkg::ADDR_W-1:0] rd_addr,
	output logic rd_word
);
	import nvm_pkg::*;
	initial begin
		cmd_valid = 1'b0;
		cmd_code = 8'h00;
		cmd_addr = '0;
		cmd_data = '0;
		cmd_words = 3'h0;
		rd_en = 1'b0;
		rd_addr = '0;
		rd_word = 1'b0;
	end
	// one whole load per call; loads meant to be accepted wait for idle and target erased, aligned places
	task automatic command(input logic [7:0] c, input logic [23:0] a, input logic [63:0] d, input logic [2:0] n);
		@(posedge clock);
		#1;
		cmd_valid = 1'b1;
		cmd_code = c;
		cmd_addr = a;
		cmd_data = d;
		cmd_words = n;
		@(posedge clock);
		#1;
		cmd_valid = 1'b0;
		// released fields carry junk, not the last value
		cmd_code = ~c;
		cmd_addr = ~a;
		cmd_data = ~d;
		cmd_words = ~n;
	endtask : command
	// word reads only at even addresses, no data reads while the program array is busy
	task automatic read(input logic [23:0] a, input logic w);
		@(posedge clock);
		#1;
		rd_en = 1'b1;
		rd_addr = a;
		rd_word = w;
	endtask : read
	task automatic release_read;
		@(posedge clock);
		#1;
		rd_en = 1'b0;
		rd_addr = ~rd_addr;
		rd_word = ~rd_word;
	endtask : release_read
endmodule : cpu_host

// ===== test/nvm_ctrl_properties.sv
`timescale 1ns/1ps
module nvm_ctrl_properties (
	input wire logic clock,
	input wire logic rst,
	input wire logic cmd_valid,
	input wire logic done_irq_en,
	input wire logic rd_en,
	input wire logic rd_word,
	input wire logic command_complete_flag,
	input wire logic cmd_error,
	input wire logic rd_valid,
	input wire logic [15:0] rd_data,
	input wire logic ecc_single,
	input wire logic ecc_double,
	input wire logic done_irq,
	input wire logic ecc_irq
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	chk_read_answer: assert property (rd_en |=> rd_valid)
		else $error("read not answered");
	chk_no_stray: assert property (!rd_en |=> !rd_valid)
		else $error("read answer without request");
	chk_byte_upper: assert property (rd_en && !rd_word |=> rd_data[15:8] == 8'h00)
		else $error("byte read upper half not zero");
	chk_cmd_outcome: assert property (cmd_valid && command_complete_flag |=> command_complete_flag == cmd_error)
		else $error("command neither started nor refused");
	chk_busy_refused: assert property (cmd_valid && !command_complete_flag |=> cmd_error)
		else $error("load while busy not flagged");
	chk_busy_hold: assert property ($fell(command_complete_flag) |-> !command_complete_flag [*8])
		else $error("busy too short");
	chk_idle_holds: assert property (command_complete_flag && !cmd_valid |=> command_complete_flag)
		else $error("idle flag dropped without command");
	chk_ecc_valid: assert property ((ecc_single || ecc_double) |-> rd_valid && !(ecc_single && ecc_double))
		else $error("fault report outside a read");
	chk_done_follow: assert property (!$past(rst) |-> done_irq == $past(done_irq_en && command_complete_flag))
		else $error("completion request wrong");
	chk_ecc_irq: assert property (ecc_irq |-> ecc_single || ecc_double)
		else $error("fault request without fault");
endmodule : nvm_ctrl_properties
bind nvm_ctrl nvm_ctrl_properties nvm_ctrl_properties_i (.clock, .rst, .cmd_valid, .done_irq_en, .rd_en, .rd_word,
	.command_complete_flag, .cmd_error, .rd_valid, .rd_data, .ecc_single, .ecc_double, .done_irq, .ecc_irq);

// ===== test/test_flash_memory_controller.sv
`timescale 1ns/1ps
module test_flash_memory_controller;
	import nvm_pkg::*;
	logic clock, rst, cmd_valid, done_irq_en, ecc_irq_en, rd_en, rd_word;
	logic [7:0] cmd_code;
	logic [ADDR_W-1:0] cmd_addr, rd_addr;
	logic [63:0] cmd_data, phrase, dwords;
	logic [2:0] cmd_words;
	logic command_complete_flag, cmd_error, verify_fail, rd_valid, ecc_single, ecc_double, done_irq, ecc_irq;
	logic [15:0] rd_data;
	logic [15:0] exp_q[$];
	logic [31:0] seed;
	int mismatches, cmp_count, i, k;
	logic [7:0] bad_code [6] = '{8'h06, 8'h0A, 8'h11, 8'h11, 8'h12, 8'hFF};
	logic [23:0] bad_addr [6] = '{24'hFE0004, 24'hFE0100, 24'h100001, 24'h100000, 24'h100002, 24'hFE0000};
	logic [2:0] bad_n [6] = '{3'h0, 3'h0, 3'h1, 3'h0, 3'h0, 3'h0};
	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end
	cpu_host cpu_host_i (.clock, .cmd_valid, .cmd_code, .cmd_addr, .cmd_data, .cmd_words, .rd_en, .rd_addr, .rd_word);
	nvm_ctrl nvm_ctrl_i (.clock, .rst, .cmd_valid, .cmd_code, .cmd_addr, .cmd_data, .cmd_words, .done_irq_en,
		.ecc_irq_en, .rd_en, .rd_addr, .rd_word, .command_complete_flag, .cmd_error, .verify_fail, .rd_valid,
		.rd_data, .ecc_single, .ecc_double, .done_irq, .ecc_irq);
	////////////////////////////////////////////////////////////////
	task automatic report_and_stop;
		// a read that never came back leaves its note behind
		if (exp_q.size() != 0) begin
			mismatches++;
		end
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : report_and_stop
	task automatic check_word(input logic [15:0] e, input logic [15:0] g);
		cmp_count++;
		if (g !== e) begin
			mismatches++;
			$display("wrong value at %0t: expected %h got %h", $time, e, g);
		end
	endtask : check_word
	task automatic check_bit(input logic e, input logic g);
		check_word({15'h0000, e}, {15'h0000, g});
	endtask : check_bit
	task automatic rd(input logic [23:0] a, input logic w, input logic [15:0] e);
		cpu_host_i.read(a, w);
		exp_q.push_back(e);
	endtask : rd
	task automatic run(input logic [7:0] c, input logic [23:0] a, input logic [63:0] d, input logic [2:0] n,
		input logic e);
		cpu_host_i.command(c, a, d, n);
		check_bit(e, cmd_error);
		check_bit(e, command_complete_flag);
	endtask : run
	task automatic wait_idle;
		for (i = 0; i < 6000 && command_complete_flag !== 1'b1; i++) begin
			@(posedge clock);
			#1;
		end
		if (command_complete_flag !== 1'b1) begin
			mismatches++;
			report_and_stop;
		end
		check_bit(1'b0, verify_fail);
	endtask : wait_idle
	// big-endian: lower-address dword in bits 31:0, its first byte on top
	function automatic logic [15:0] pbyte(input logic [63:0] d, input int n);
		logic [31:0] dw;
		dw = n < 4 ? d[31:0] : d[63:32];
		return {8'h00, dw[31 - 8 * (n % 4) -: 8]};
	endfunction : pbyte
	////////////////////////////////////////////////////////////////
	always @(negedge clock) begin
		if (rd_valid === 1'b1) begin
			check_word(exp_q.size() > 0 ? exp_q.pop_front() : 16'hXXXX, rd_data);
			check_bit(1'b0, ecc_single | ecc_double);
			check_bit(1'b0, ecc_irq);
		end
	end
	initial begin
		seed = 32'hAA2A22D7;
		mismatches = 0;
		cmp_count = 0;
		rst = 1'b1;
		done_irq_en = 1'($random(seed));
		ecc_irq_en = 1'b1;
		phrase = {$random(seed), $random(seed)};
		dwords = {$random(seed), $random(seed)};
		repeat (3) @(posedge clock);
		#1;
		rst = 1'b0;
		check_bit(1'b1, command_complete_flag);
		for (k = 0; k < 6; k++) run(bad_code[k], bad_addr[k], phrase, bad_n[k], 1'b1);
		run(CMD_ERS_PSECTOR, PFL_BASE, phrase, 3'h0, 1'b0);
		wait_idle;
		rd(PFL_BASE, 1'b0, 16'h00FF);
		rd(PFL_BASE + 24'h0001FE, 1'b1, 16'hFFFF);
		cpu_host_i.release_read;
		run(CMD_PGM_PHRASE, PFL_BASE, phrase, 3'h0, 1'b0);
		wait_idle;
		run(CMD_ERS_DSECTOR, DFL_BASE, dwords, 3'h0, 1'b0);
		wait_idle;
		rd(DFL_BASE, 1'b1, 16'hFFFF);
		rd(DFL_BASE + 24'h000002, 1'b1, 16'hFFFF);
		cpu_host_i.release_read;
		run(CMD_PGM_DWORDS, DFL_BASE, dwords, 3'h2, 1'b0);
		// program array stays readable while the data array is busy, back to back
		for (k = 0; k < 8; k++) rd(PFL_BASE + 24'(k), 1'b0, pbyte(phrase, k));
		rd(PFL_BASE + 24'h000004, 1'b1, phrase[63:48]);
		cpu_host_i.release_read;
		cpu_host_i.command(CMD_ERS_DSECTOR, DFL_BASE, dwords, 3'h0);
		check_bit(1'b1, cmd_error);
		check_bit(1'b0, command_complete_flag);
		wait_idle;
		@(posedge clock);
		#1;
		check_bit(done_irq_en, done_irq);
		rd(DFL_BASE, 1'b1, dwords[15:0]);
		rd(DFL_BASE + 24'h000002, 1'b1, dwords[31:16]);
		rd(RES_BASE, 1'b1, 16'hFFFF);
		rd(RES_BASE + 24'h000001, 1'b0, 16'h00FF);
		rd(24'h000010, 1'b1, 16'h0000);
		rd(DFL_BASE + 24'h000001, 1'b0, {8'h00, dwords[7:0]});
		cpu_host_i.release_read;
		repeat (3) @(posedge clock);
		report_and_stop;
	end
endmodule : test_flash_memory_controller
